// ==== rtl/spg_gpio_top.sv ====
// general-purpose ports on shared pins with an axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none

module spg_gpio_top #(
	parameter int ADDR_W    = 10,
	parameter bit HAS_PORT_E = 1'b1
) (
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              host_serial_mode,
	input  wire logic              pwm_enable,
	input  wire logic              spi_master_enable,
	input  wire logic              panel_bus_16,
	input  wire logic              panel_bus_12,
	output logic                   i2c_master_data_pin_out,
	output logic                   i2c_master_data_pin_oe,
	input  wire logic              i2c_master_clock_pin_in,
	input  wire logic [3:0]        host_strobe_pins_in,
	output logic [3:0]             host_strobe_pins_out,
	output logic [3:0]             host_strobe_pins_oe,
	input  wire logic [7:0]        port_c_in,
	output logic [7:0]             port_c_out,
	output logic [7:0]             port_c_oe,
	input  wire logic [23:0]       panel_data_lines_in,
	output logic [23:0]            panel_data_lines_out,
	output logic [23:0]            panel_data_lines_oe
);

	if (ADDR_W < spg_pkg::MIN_ADDR_W) begin : g_bad
		$error("spg_gpio_top: ADDR_W too small for the register map");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic                   aw_rdy;
		logic                   aw_got;
		logic [ADDR_W-1:0]      aw_addr;
		logic                   w_rdy;
		logic                   w_got;
		logic [7:0]             wdat;
		logic                   wstb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic                   lock;
		logic [5:0]             b_ctrl;
		logic [4:0]             b_smp;
		logic                   i2c_out;
		logic                   i2c_oe;
		logic [3:0]             host_out;
		logic [3:0]             host_oe;
		logic [3:0][7:0]        dir;
		logic [3:0][7:0]        data;
	} spg_state_t;

	spg_state_t      s;
	spg_state_t      next_s;
	logic [3:0][7:0] avail;
	logic [3:0][7:0] pin_in;
	logic [3:0][7:0] pin_out;
	logic [3:0][7:0] pin_oe;
	logic [3:0][7:0] sampled;
	logic            wr_fire;
	logic [7:0]      wr_idx;
	logic [7:0]      rd_idx;

	// ==========================================================
	// address decode helpers
	function automatic logic in_range(input logic [ADDR_W-1:0] a);
		in_range = ((a >> spg_pkg::MIN_ADDR_W) == '0);
	endfunction

	function automatic logic mapped(input logic [7:0] idx);
		logic hit;
		hit = 1'b0;
		case (idx)
			spg_pkg::IDX_LOCK, spg_pkg::IDX_PORT_B,
			spg_pkg::IDX_C_DIR, spg_pkg::IDX_C_DATA,
			spg_pkg::IDX_D_DIR, spg_pkg::IDX_D_DATA,
			spg_pkg::IDX_F_DIR, spg_pkg::IDX_F_DATA: hit = 1'b1;
			spg_pkg::IDX_E_DIR, spg_pkg::IDX_E_DATA: hit = HAS_PORT_E;
			default: hit = 1'b0;
		endcase
		mapped = hit;
	endfunction

	assign wr_idx  = s.aw_addr[spg_pkg::IDX_MSB:spg_pkg::IDX_LSB];
	assign rd_idx  = s_axi_araddr[spg_pkg::IDX_MSB:spg_pkg::IDX_LSB];
	assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;

	// ==========================================================
	// pin grants from the functions that share the pins
	always_comb begin
		avail[0] = ~(({8{pwm_enable | spi_master_enable}} & spg_pkg::C_PWM_SPI_MASK)
			| ({8{spi_master_enable}} & spg_pkg::C_SPI_MASK));
		avail[1] = ({8{panel_bus_16 | panel_bus_12}} & spg_pkg::D_BUS12_MASK)
			| ({8{panel_bus_16}} & spg_pkg::D_BUS16_MASK);
		avail[2] = {8{HAS_PORT_E}};
		avail[3] = 8'hFF;
	end

	// ==========================================================
	// panel line mapping of ports d, e and f
	for (genvar k = 0; k < 8; k++) begin : g_map
		assign pin_in[1][k] = panel_data_lines_in[spg_pkg::PORT_D_LINES[k]];
		assign pin_in[2][k] = panel_data_lines_in[spg_pkg::PORT_E_LINES[k]];
		assign pin_in[3][k] = panel_data_lines_in[spg_pkg::PORT_F_LINES[k]];
		assign panel_data_lines_out[spg_pkg::PORT_D_LINES[k]] = pin_out[1][k];
		assign panel_data_lines_oe[spg_pkg::PORT_D_LINES[k]]  = pin_oe[1][k];
		assign panel_data_lines_out[spg_pkg::PORT_E_LINES[k]] = pin_out[2][k];
		assign panel_data_lines_oe[spg_pkg::PORT_E_LINES[k]]  = pin_oe[2][k];
		assign panel_data_lines_out[spg_pkg::PORT_F_LINES[k]] = pin_out[3][k];
		assign panel_data_lines_oe[spg_pkg::PORT_F_LINES[k]]  = pin_oe[3][k];
	end
	assign pin_in[0] = port_c_in;

	// ==========================================================
	// one bank per port c, d, e, f
	for (genvar p = 0; p < spg_pkg::PORTS; p++) begin : g_port
		spg_pin_bank #(
			.WIDTH(8)
		) u_bank (
			.sys_clk(sys_clk),
			.srst   (srst),
			.data   (s.data[p]),
			.dir    (s.dir[p]),
			.avail  (avail[p]),
			.pin_in (pin_in[p]),
			.pin_out(pin_out[p]),
			.pin_oe (pin_oe[p]),
			.sampled(sampled[p])
		);
	end
	assign port_c_out = pin_out[0];
	assign port_c_oe  = pin_oe[0];

	// ==========================================================
	// next state: bus slave, register writes, reads and port b pins
	always_comb begin
		next_s = s;
		// write address and data are taken independently
		if (s_axi_awvalid && s.aw_rdy) begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.w_rdy) begin
			next_s.w_got = 1'b1;
			next_s.wdat  = s_axi_wdata[7:0];
			next_s.wstb  = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// both halves present: perform the write and answer
		if (wr_fire) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = spg_pkg::RESP_SLVERR;
			if (in_range(s.aw_addr) && mapped(wr_idx)) begin
				next_s.bresp = spg_pkg::RESP_OKAY;
				if (s.wstb && wr_idx == spg_pkg::IDX_LOCK) begin
					next_s.lock = s.wdat[spg_pkg::LOCK_BIT];
				end else if (s.wstb && !s.lock) begin
					case (wr_idx)
						spg_pkg::IDX_PORT_B: next_s.b_ctrl = s.wdat[5:0];
						spg_pkg::IDX_C_DIR:  next_s.dir[0] = s.wdat;
						spg_pkg::IDX_C_DATA: next_s.data[0] = s.wdat;
						spg_pkg::IDX_D_DIR:  next_s.dir[1] = s.wdat;
						spg_pkg::IDX_D_DATA: next_s.data[1] = s.wdat;
						spg_pkg::IDX_E_DIR:  next_s.dir[2] = s.wdat;
						spg_pkg::IDX_E_DATA: next_s.data[2] = s.wdat;
						spg_pkg::IDX_F_DIR:  next_s.dir[3] = s.wdat;
						spg_pkg::IDX_F_DATA: next_s.data[3] = s.wdat;
						default:             next_s.lock = s.lock;
					endcase
				end
			end
		end
		next_s.aw_rdy = ~next_s.aw_got;
		next_s.w_rdy  = ~next_s.w_got;
		// reads answer one cycle after the address is taken
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = '0;
			next_s.rresp  = spg_pkg::RESP_SLVERR;
			if (in_range(s_axi_araddr) && mapped(rd_idx)) begin
				next_s.rresp = spg_pkg::RESP_OKAY;
				case (rd_idx)
					spg_pkg::IDX_LOCK:   next_s.rdata[spg_pkg::LOCK_BIT] = s.lock;
					spg_pkg::IDX_PORT_B: next_s.rdata[5:0] = {s.b_ctrl[spg_pkg::B_FLOAT_BIT], s.b_smp};
					spg_pkg::IDX_C_DIR:  next_s.rdata[7:0] = s.dir[0];
					spg_pkg::IDX_C_DATA: next_s.rdata[7:0] = sampled[0];
					spg_pkg::IDX_D_DIR:  next_s.rdata[7:0] = s.dir[1];
					spg_pkg::IDX_D_DATA: next_s.rdata[7:0] = sampled[1];
					spg_pkg::IDX_E_DIR:  next_s.rdata[7:0] = s.dir[2];
					spg_pkg::IDX_E_DATA: next_s.rdata[7:0] = sampled[2];
					spg_pkg::IDX_F_DIR:  next_s.rdata[7:0] = s.dir[3];
					spg_pkg::IDX_F_DATA: next_s.rdata[7:0] = sampled[3];
					default:             next_s.rdata = '0;
				endcase
			end
		end
		next_s.arready = ~next_s.rvalid;
		// port b pins: i2c data driven, i2c clock read back
		next_s.b_smp    = {i2c_master_clock_pin_in, host_strobe_pins_in};
		next_s.i2c_out  = s.b_ctrl[spg_pkg::B_I2C_BIT];
		next_s.i2c_oe   = ~s.b_ctrl[spg_pkg::B_FLOAT_BIT];
		next_s.host_out = s.b_ctrl[3:0];
		next_s.host_oe  = {4{~s.b_ctrl[spg_pkg::B_FLOAT_BIT] & host_serial_mode}};
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s         <= '0;
			s.aw_rdy  <= 1'b1;
			s.w_rdy   <= 1'b1;
			s.arready <= 1'b1;
			s.b_ctrl  <= spg_pkg::B_RESET;
			s.dir     <= {spg_pkg::PORTS{spg_pkg::DIR_RESET}};
			s.data    <= {spg_pkg::PORTS{spg_pkg::DATA_RESET}};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready           = s.aw_rdy;
	assign s_axi_wready            = s.w_rdy;
	assign s_axi_bvalid            = s.bvalid;
	assign s_axi_bresp             = s.bresp;
	assign s_axi_arready           = s.arready;
	assign s_axi_rvalid            = s.rvalid;
	assign s_axi_rdata             = s.rdata;
	assign s_axi_rresp             = s.rresp;
	assign i2c_master_data_pin_out = s.i2c_out;
	assign i2c_master_data_pin_oe  = s.i2c_oe;
	assign host_strobe_pins_out    = s.host_out;
	assign host_strobe_pins_oe     = s.host_oe;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	dir_reset_a: assert property ($past(srst) |-> s.dir == {spg_pkg::PORTS{spg_pkg::DIR_RESET}})
		else $error("direction registers not all input after reset");
	b_float_a: assert property (s.b_ctrl[spg_pkg::B_FLOAT_BIT] |=> (!i2c_master_data_pin_oe && host_strobe_pins_oe == 4'h0))
		else $error("port b drives while floating");
	b_drive_a: assert property (!s.b_ctrl[spg_pkg::B_FLOAT_BIT] |=> i2c_master_data_pin_oe && i2c_master_data_pin_out == $past(s.b_ctrl[spg_pkg::B_I2C_BIT]))
		else $error("port b bit 4 not driven on i2c data pin");
	b_clock_read_a: assert property ((s_axi_arvalid && s_axi_arready && in_range(s_axi_araddr) && rd_idx == spg_pkg::IDX_PORT_B)
		|=> s_axi_rvalid && s_axi_rdata[spg_pkg::B_I2C_BIT] == $past(i2c_master_clock_pin_in, 2))
		else $error("port b bit 4 read is not the i2c clock pin");
	host_mode_a: assert property (!host_serial_mode |=> host_strobe_pins_oe == 4'h0)
		else $error("host strobe pins driven outside serial mode");
	c_pwm_a: assert property ((pwm_enable || spi_master_enable) |=> (port_c_oe & spg_pkg::C_PWM_SPI_MASK) == 8'h00)
		else $error("port c driven while pwm or spi master on");
	c_spi_a: assert property (spi_master_enable |=> (port_c_oe & spg_pkg::C_SPI_MASK) == 8'h00)
		else $error("port c quad pins driven while spi master on");
	d_width_a: assert property (!panel_bus_16 |=> !panel_data_lines_oe[18] && !panel_data_lines_oe[2]
		&& !panel_data_lines_oe[9] && !panel_data_lines_oe[8])
		else $error("port d wide bits driven on narrow panel bus");
	lock_hold_a: assert property ((wr_fire && s.lock && wr_idx != spg_pkg::IDX_LOCK) |=> $stable(s.dir) && $stable(s.data) && $stable(s.b_ctrl))
		else $error("register changed while locked");
	data_write_a: assert property ((wr_fire && !s.lock && s.wstb && in_range(s.aw_addr) && wr_idx == spg_pkg::IDX_F_DATA)
		|=> ##1 port_f_match(s.data[3]))
		else $error("port f pins do not carry written data");

	// a pin whose direction bit was 1 never drives on the next edge
	dir_input_a: assert property (1'b1 |=> (pin_oe & $past(s.dir)) == '0)
		else $error("input pin driven");

	// lock bit follows its own write even while locked
	lock_set_a: assert property ((wr_fire && s.wstb && in_range(s.aw_addr) && wr_idx == spg_pkg::IDX_LOCK)
		|=> s.lock == $past(s.wdat[spg_pkg::LOCK_BIT]))
		else $error("lock bit write lost");

	// serial host mode with drive enabled puts the latch on the strobe pins
	host_drive_a: assert property ((host_serial_mode && !s.b_ctrl[spg_pkg::B_FLOAT_BIT])
		|=> host_strobe_pins_oe == 4'hF && host_strobe_pins_out == $past(s.b_ctrl[3:0]))
		else $error("host strobe pins not driven from port b latch");

	// no port d pin drives without a panel width that grants it
	d_narrow_a: assert property (!(panel_bus_16 || panel_bus_12) |=> pin_oe[1] == 8'h00)
		else $error("port d driven with no panel width granted");

	// unmapped reads answer an error with zero data
	bad_read_a: assert property ((s_axi_arvalid && s_axi_arready && !(in_range(s_axi_araddr) && mapped(rd_idx)))
		|=> s_axi_rresp == spg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");

	// lock bit reads back as stored
	lock_read_a: assert property ((s_axi_arvalid && s_axi_arready && in_range(s_axi_araddr)
		&& rd_idx == spg_pkg::IDX_LOCK) |=> s_axi_rdata[spg_pkg::LOCK_BIT] == $past(s.lock))
		else $error("lock bit read back wrong");

	function automatic logic port_f_match(input logic [7:0] d);
		logic ok;
		ok = 1'b1;
		for (int k = 0; k < 8; k++) begin
			ok = ok && (panel_data_lines_out[spg_pkg::PORT_F_LINES[k]] == d[k]);
		end
		port_f_match = ok;
	endfunction

endmodule

`default_nettype wire

// ==== rtl/spg_pkg.sv ====
// constants shared by the shared-pin general-purpose port block
package spg_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_LOCK   = 8'h00;
	localparam logic [7:0] IDX_PORT_B = 8'hF2;
	localparam logic [7:0] IDX_C_DIR  = 8'hF3;
	localparam logic [7:0] IDX_C_DATA = 8'hF4;
	localparam logic [7:0] IDX_D_DIR  = 8'hF5;
	localparam logic [7:0] IDX_D_DATA = 8'hF6;
	localparam logic [7:0] IDX_E_DIR  = 8'hF7;
	localparam logic [7:0] IDX_E_DATA = 8'hF8;
	localparam logic [7:0] IDX_F_DIR  = 8'hF9;
	localparam logic [7:0] IDX_F_DATA = 8'hFA;

	// ==========================================================
	// field positions
	localparam int LOCK_BIT     = 2;
	localparam int B_FLOAT_BIT  = 5;
	localparam int B_I2C_BIT    = 4;
	localparam int IDX_LSB      = 2;
	localparam int IDX_MSB      = 9;
	localparam int MIN_ADDR_W   = 10;
	localparam int PORTS        = 4;

	// ==========================================================
	// reset values
	localparam logic [7:0] DIR_RESET  = 8'hFF;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [5:0] B_RESET    = 6'h00;

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// pin sharing masks for ports c and d
	localparam logic [7:0] C_PWM_SPI_MASK = 8'h9F;
	localparam logic [7:0] C_SPI_MASK     = 8'h60;
	localparam logic [7:0] D_BUS12_MASK   = 8'h33;
	localparam logic [7:0] D_BUS16_MASK   = 8'hCC;

	// ==========================================================
	// panel data line carried by each port bit, element 7 first
	localparam logic [7:0][4:0] PORT_D_LINES = {5'h12, 5'h02, 5'h11, 5'h10, 5'h09, 5'h08, 5'h01, 5'h00};
	localparam logic [7:0][4:0] PORT_E_LINES = {5'h0C, 5'h0B, 5'h0A, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03};
	localparam logic [7:0][4:0] PORT_F_LINES = {5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h0F, 5'h0E, 5'h0D};

endpackage

// ==== rtl/spg_pin_bank.sv ====
// one eight-pin port: registered pin drive and input sampling
`timescale 1ns/1ns
`default_nettype none

module spg_pin_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] avail,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe,
	output logic      [WIDTH-1:0] sampled
);

	typedef struct packed {
		logic [WIDTH-1:0] out;
		logic [WIDTH-1:0] oe;
		logic [WIDTH-1:0] smp;
	} spg_bank_t;

	spg_bank_t        s;
	spg_bank_t        next_s;
	logic [WIDTH-1:0] next_oe;

	if (WIDTH < 1) begin : g_bad
		$error("spg_pin_bank: WIDTH must be at least 1");
	end

	// ==========================================================
	// per bit drive decision
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// a zero direction bit makes an output, only while the pin is granted
		assign next_oe[i] = ~dir[i] & avail[i];
	end

	// latch always follows data, so a value written as input shows on turning output
	always_comb begin
		next_s.out = data;
		next_s.oe  = next_oe;
		next_s.smp = pin_in;
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pin_out = s.out;
	assign pin_oe  = s.oe;
	assign sampled = s.smp;

endmodule

`default_nettype wire

// ==== dv/spg_pin_partner.sv ====
// external components that sit on the shared general-purpose pins
`timescale 1ns/1ns
`default_nettype none

module spg_pin_partner (
	input  wire logic        ext_clk,
	output logic             clk_pin,
	input  wire logic [3:0]  host_out,
	input  wire logic [3:0]  host_oe,
	input  wire logic [3:0]  ext_host,
	output logic [3:0]       host_pin,
	input  wire logic [7:0]  c_out,
	input  wire logic [7:0]  c_oe,
	input  wire logic [7:0]  ext_c,
	output logic [7:0]       c_pin,
	input  wire logic [23:0] pl_out,
	input  wire logic [23:0] pl_oe,
	input  wire logic [23:0] ext_pl,
	output logic [23:0]      pl_pin
);
	// ==========================================================
	// wire levels: the block wins where it drives, else the component
	assign clk_pin  = ext_clk;
	assign host_pin = (host_oe & host_out) | (~host_oe & ext_host);
	assign c_pin    = (c_oe & c_out) | (~c_oe & ext_c);
	assign pl_pin   = (pl_oe & pl_out) | (~pl_oe & ext_pl);
endmodule

`default_nettype wire

// ==== dv/spg_gpio_top_tb_top.sv ====
// self-checking bench for the shared-pin general-purpose ports
`timescale 1ns/1ns
`default_nettype none

module spg_gpio_top_tb_top;
	logic        sys_clk = 1'b0, srst = 1'b1;
	logic [9:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, last_resp;
	logic        serial = 1'b0, pwm = 1'b0, spi = 1'b0, b16 = 1'b0, b12 = 1'b0;
	logic        i2c_out, i2c_oe, clk_pin, ext_clk = 1'b0;
	logic [3:0]  host_pin, host_out, host_oe, ext_host = 4'h0;
	logic [7:0]  c_pin, c_out, c_oe, ext_c = 8'h00;
	logic [23:0] pl_pin, pl_out, pl_oe, ext_pl = 24'h0;
	int          miscompares = 0, compares = 0, cycles = 0;
	// panel line carried by each bit of ports d, e and f
	localparam int LN[3][8] = '{'{0, 1, 8, 9, 16, 17, 2, 18}, '{3, 4, 5, 6, 7, 10, 11, 12},
		'{13, 14, 15, 19, 20, 21, 22, 23}};

	// ==========================================================
	// instances
	spg_gpio_top dut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_serial_mode(serial),
		.pwm_enable(pwm), .spi_master_enable(spi), .panel_bus_16(b16), .panel_bus_12(b12),
		.i2c_master_data_pin_out(i2c_out), .i2c_master_data_pin_oe(i2c_oe),
		.i2c_master_clock_pin_in(clk_pin), .host_strobe_pins_in(host_pin), .host_strobe_pins_out(host_out),
		.host_strobe_pins_oe(host_oe), .port_c_in(c_pin), .port_c_out(c_out), .port_c_oe(c_oe),
		.panel_data_lines_in(pl_pin), .panel_data_lines_out(pl_out), .panel_data_lines_oe(pl_oe));
	spg_pin_partner ext (.ext_clk(ext_clk), .clk_pin(clk_pin), .host_out(host_out), .host_oe(host_oe),
		.ext_host(ext_host), .host_pin(host_pin), .c_out(c_out), .c_oe(c_oe), .ext_c(ext_c), .c_pin(c_pin),
		.pl_out(pl_out), .pl_oe(pl_oe), .ext_pl(ext_pl), .pl_pin(pl_pin));

	// ==========================================================
	// clock, timeout and verdict
	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim;
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [23:0] spread(input int p, input logic [7:0] v);
		spread = '0;
		for (int k = 0; k < 8; k++) spread[LN[p][k]] = v[k];
	endfunction

	// ==========================================================
	// bus master tasks, waits cut short only by the timeout
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge sys_clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		last_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		@(posedge sys_clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		last_resp = rresp;
		check(name, rdata, exp);
		rready <= 1'b0;
	endtask

	task automatic settle;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic pins(input int p, input logic [7:0] g, input logic [7:0] v);
		logic [23:0] m;
		settle();
		m = spread(p, 8'hFF);
		check("panel oe", {8'h0, pl_oe & m}, {8'h0, spread(p, g)});
		check("panel out", {8'h0, pl_out & pl_oe & m}, {8'h0, spread(p, v & g)});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		for (logic [7:0] i = 8'hF3; i < 8'hFA; i += 8'h02) rdchk("dir reset", i, 32'hFF);
		check("c oe reset", {24'h0, c_oe}, 32'h0);
	endtask

	task automatic t_port_f;
		ext_pl <= ~spread(2, 8'h55);
		wr(8'hFA, 8'h55);
		pins(2, 8'h00, 8'h00);
		rdchk("f in", 8'hFA, 32'hAA);
		wr(8'hF9, 8'h00);
		pins(2, 8'hFF, 8'h55);
		rdchk("f out", 8'hFA, 32'h55);
		wr(8'hF9, 8'hF0);
		pins(2, 8'h0F, 8'h55);
		rdchk("f mix", 8'hFA, 32'hA5);
	endtask

	task automatic t_port_d;
		wr(8'hF5, 8'h00);
		wr(8'hF6, 8'hA5);
		for (int i = 0; i < 4; i++) begin
			b16 <= i[1];
			b12 <= i[0];
			pins(0, i[1] ? 8'hFF : (i[0] ? 8'h33 : 8'h00), 8'hA5);
		end
		wr(8'hF7, 8'h00);
		wr(8'hF8, 8'h3C);
		pins(1, 8'hFF, 8'h3C);
		rdchk("e rd", 8'hF8, 32'h3C);
	endtask

	task automatic t_port_c;
		logic [7:0] g;
		ext_c <= 8'h5A;
		wr(8'hF3, 8'h00);
		wr(8'hF4, 8'hC3);
		for (int i = 0; i < 4; i++) begin
			pwm <= i[1];
			spi <= i[0];
			settle();
			g = i[0] ? 8'h00 : (i[1] ? 8'h60 : 8'hFF);
			check("c oe", {24'h0, c_oe}, {24'h0, g});
			check("c out", {24'h0, c_out & c_oe}, {24'h0, 8'hC3 & g});
			rdchk("c rd", 8'hF4, {24'h0, (8'hC3 & g) | (8'h5A & ~g)});
		end
	endtask

	task automatic t_port_b;
		ext_host <= 4'h5;
		ext_clk <= 1'b1;
		serial <= 1'b1;
		wr(8'hF2, 8'h1A);
		settle();
		check("b oe", {27'h0, i2c_oe, host_oe}, 32'h1F);
		check("b out", {27'h0, i2c_out, host_out}, 32'h1A);
		rdchk("b rd", 8'hF2, 32'h1A);
		serial <= 1'b0;
		settle();
		check("b host oe", {28'h0, host_oe}, 32'h0);
		rdchk("b rd", 8'hF2, 32'h15);
		ext_clk <= 1'b0;
		serial <= 1'b1;
		wr(8'hF2, 8'h3A);
		settle();
		check("b float", {27'h0, i2c_oe, host_oe}, 32'h0);
		rdchk("b rd", 8'hF2, 32'h25);
	endtask

	task automatic t_lock;
		wr(8'h00, 8'h04);
		rdchk("lock rd", 8'h00, 32'h04);
		wr(8'hF9, 8'h3C);
		wr(8'hF2, 8'h00);
		check("locked bresp", {30'h0, last_resp}, 32'h0);
		rdchk("locked f", 8'hF9, 32'hF0);
		rdchk("locked b", 8'hF2, 32'h25);
		wr(8'h00, 8'h00);
		wr(8'hF9, 8'h3C);
		rdchk("unlocked f", 8'hF9, 32'h3C);
		wstrb <= 4'h0;
		wr(8'hF9, 8'h11);
		wstrb <= 4'hF;
		rdchk("no strobe", 8'hF9, 32'h3C);
		wr(8'h10, 8'h01);
		check("unmapped wr", {30'h0, last_resp}, 32'h2);
		rdchk("unmapped rd", 8'h10, 32'h0);
		check("unmapped rresp", {30'h0, last_resp}, 32'h2);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_port_f();
		t_port_d();
		t_port_c();
		t_port_b();
		t_lock();
		end_sim();
	end
endmodule

`default_nettype wire
